/* File: verilog/adcrp_params.svh */
// Purpose: named constants for the converter read port
// Assumes: 20 MHz system clock, 50 ns period
// Notes:   times in ns, cycle counts derived from them
`ifndef ADCRP_PARAMS_SVH
`define ADCRP_PARAMS_SVH
`define ADCRP_CLK_PERIOD_NS 50
`define ADCRP_MAX_CONV_MHZ  20
`define ADCRP_DATA_W        8
`define ADCRP_FIFO_DEPTH    4
// pipeline delay of 2.5 cycles: sample on fall, result 3 rising edges later
`define ADCRP_PIPE_HALF     5
`define ADCRP_PIPE_STAGES   ((`ADCRP_PIPE_HALF + 1) / 2)
`define ADCRP_SEL_ACTIVE    1'b1
`define ADCRP_STB_ACTIVE    1'b0
`endif

/* File: verilog/adcrp_pkg.sv */
// Purpose: types shared by the converter read port
// Assumes: adcrp_params.svh included
// Notes:   sample word travels as a struct
`include "adcrp_params.svh"
package adcrp_pkg;
  typedef logic [`ADCRP_DATA_W-1:0] adcrp_byte_t;
  typedef struct packed
  {
    logic        valid;
    adcrp_byte_t data;
  } adcrp_smp_s;
endpackage

/* File: verilog/adcrp_top.sv */
// Purpose: sampling converter digital side with tri-state read port to a processor
// Assumes: one free running 20 MHz clock; processor strobes are asynchronous pins
// Notes:   read data comes from the newest result at the output of a 4 word FIFO that is drained every clock
`timescale 1ns/10ps
`include "adcrp_params.svh"

module adcrp_fifo #(
  parameter int WIDTH = `ADCRP_DATA_W,
  parameter int DEPTH = `ADCRP_FIFO_DEPTH
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             wr, rd;

  function automatic logic [AW-1:0] adcrp_inc(input logic [AW-1:0] p);
    adcrp_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // honest full and empty flags drive the handshakes
  assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem_r[rp_r];
  assign wr          = i_in_valid & o_in_ready;
  assign rd          = o_out_valid & i_out_ready;

  // pointer and count next state
  always_comb
  begin
    wp_nxt  = wr ? adcrp_inc(wp_r) : wp_r;
    rp_nxt  = rd ? adcrp_inc(rp_r) : rp_r;
    cnt_nxt = cnt_r;
    if (wr && !rd)
    begin
      cnt_nxt = cnt_r + 1'b1;
    end
    else if (rd && !wr)
    begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // storage has no reset; contents are qualified by the count
  always_ff @(posedge i_sys_clk)
  begin
    if (wr)
    begin
      mem_r[wp_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

module adcrp_top #(
  parameter int DATA_W     = `ADCRP_DATA_W,
  parameter int FIFO_DEPTH = `ADCRP_FIFO_DEPTH
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_resetn,
  input  wire logic [DATA_W-1:0] i_analog_code,
  input  wire logic              i_converter_select_address_bit,
  input  wire logic              i_io_space_strobe_n,
  output logic      [DATA_W-1:0] o_bus_data,
  output logic                   o_bus_data_oe,
  output logic                   o_drv_oe_n,
  output logic      [DATA_W-1:0] o_conv_data,
  output logic                   o_sample_valid,
  output logic                   o_overrun
);
  localparam int STAGES = `ADCRP_PIPE_STAGES;

  logic [DATA_W-1:0] smp_neg_r;
  logic [DATA_W-1:0] pipe_r [STAGES];
  logic [DATA_W-1:0] pipe_nxt [STAGES];
  logic [STAGES-1:0] pv_r, pv_nxt;
  logic [1:0]        sel_sync_r, stb_sync_r;
  logic              rd_active, rd_active_d_r, rd_start;
  adcrp_pkg::adcrp_smp_s newest_r, newest_nxt;
  logic [DATA_W-1:0] bus_r, bus_nxt;
  logic              oe_r, oe_nxt, ovr_r, ovr_nxt;
  logic              f_in_ready, f_out_valid, f_pop;
  logic [DATA_W-1:0] f_out_data;

  // falling edge sample of the analog code; no reset, it is a data path
  always_ff @(negedge i_sys_clk)
  begin
    smp_neg_r <= i_analog_code;
  end

  // result pipeline: half cycle from the fall plus whole stages, 2.5 in total
  always_comb
  begin
    pipe_nxt[0] = smp_neg_r;
    pv_nxt      = {pv_r[STAGES-2:0], 1'b1};
    for (int i = 1; i < STAGES; i++)
    begin
      pipe_nxt[i] = pipe_r[i-1];
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    pipe_r <= pipe_nxt;
    if (!i_resetn)
    begin
      pv_r <= '0;
    end
    else
    begin
      pv_r <= pv_nxt;
    end
  end

  // one word per clock at most; the fifo is popped every clock it holds a word, so it keeps only the newest result
  adcrp_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_resetn    (i_resetn),
    .i_in_valid  (pv_r[STAGES-1]),
    .o_in_ready  (f_in_ready),
    .i_in_data   (pipe_r[STAGES-1]),
    .o_out_valid (f_out_valid),
    .i_out_ready (f_pop),
    .o_out_data  (f_out_data)
  );

  // drain the oldest word whenever not empty so the fifo never fills and the pipeline never stalls
  assign f_pop = f_out_valid & (~f_in_ready | 1'b1);

  // processor strobes are asynchronous pins: two flops before any logic
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      sel_sync_r    <= '0;
      stb_sync_r    <= 2'h3;
      rd_active_d_r <= 1'b0;
    end
    else
    begin
      sel_sync_r    <= {sel_sync_r[0], i_converter_select_address_bit};
      stb_sync_r    <= {stb_sync_r[0], i_io_space_strobe_n};
      rd_active_d_r <= rd_active;
    end
  end

  // decode: bit 11 high and strobe low select the converter
  assign rd_active = (sel_sync_r[1] == `ADCRP_SEL_ACTIVE)
                   & (stb_sync_r[1] == `ADCRP_STB_ACTIVE);
  assign rd_start  = rd_active & ~rd_active_d_r;

  // newest result tracks the fifo output; bus word is latched from it at read start and held until the next read
  always_comb
  begin
    newest_nxt = newest_r;
    bus_nxt    = bus_r;
    ovr_nxt    = ovr_r;
    if (f_out_valid)
    begin
      newest_nxt.valid = 1'b1;
      newest_nxt.data  = f_out_data;
    end
    if (rd_start)
    begin
      bus_nxt = newest_r.data;
      ovr_nxt = 1'b0;
    end
    else if (f_out_valid && !f_in_ready)
    begin
      ovr_nxt = 1'b1;  // reader fell behind; the clear above wins over this set
    end
    oe_nxt = rd_active;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      newest_r <= '0;
      bus_r    <= '0;
      oe_r     <= 1'b0;
      ovr_r    <= 1'b0;
    end
    else
    begin
      newest_r <= newest_nxt;
      bus_r    <= bus_nxt;
      oe_r     <= oe_nxt;
      ovr_r    <= ovr_nxt;
    end
  end

  // bit order kept straight: converter line one is bus bit zero
  assign o_bus_data     = bus_r;
  assign o_bus_data_oe  = oe_r;
  assign o_drv_oe_n     = ~oe_r;
  assign o_conv_data    = newest_r.data;
  assign o_sample_valid = newest_r.valid;
  assign o_overrun      = ovr_r;
endmodule

/* File: tb/adcrp_top_monitor.sv */
// Purpose: port checker for the converter read port
// Assumes: bound to adcrp_top, 2 flop sync plus output register
// Notes:   pin levels are held several cycles by the reader
`timescale 1ns/10ps
module adcrp_top_monitor #(
  parameter int DATA_W     = 8,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic              i_sys_clk,
  input wire logic              i_resetn,
  input wire logic [DATA_W-1:0] i_analog_code,
  input wire logic              i_converter_select_address_bit,
  input wire logic              i_io_space_strobe_n,
  input wire logic [DATA_W-1:0] o_bus_data,
  input wire logic              o_bus_data_oe,
  input wire logic              o_drv_oe_n,
  input wire logic [DATA_W-1:0] o_conv_data,
  input wire logic              o_sample_valid,
  input wire logic              o_overrun
);
  // one domain: shared clock and reset
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  a_oen_inverse: assert property (o_drv_oe_n != o_bus_data_oe)
    else $error("enable pins disagree");
  a_oe_from_decode: assert property ($rose(o_bus_data_oe) |->
    $past(i_converter_select_address_bit, 3) && !$past(i_io_space_strobe_n, 3))
    else $error("bus driven without decode");
  a_oe_on_read: assert property (
    (i_converter_select_address_bit && !i_io_space_strobe_n)[*4] |-> o_bus_data_oe)
    else $error("read not answered");
  a_bus_idle: assert property (
    (!i_converter_select_address_bit || i_io_space_strobe_n)[*4] |-> !o_bus_data_oe)
    else $error("bus driven when idle");
  a_data_holds: assert property (o_bus_data_oe && $past(o_bus_data_oe) |->
    $stable(o_bus_data)) else $error("read data moved");
  a_conv_tracks: assert property ($stable(i_analog_code)[*8] ##0 o_sample_valid
    |-> o_conv_data == i_analog_code) else $error("result lags");
  a_reset_quiet: assert property (disable iff (1'b0) !i_resetn |=>
    !o_bus_data_oe && !o_sample_valid && !o_overrun) else $error("reset state");
  a_valid_sticks: assert property (o_sample_valid |=> o_sample_valid)
    else $error("valid dropped");
endmodule
bind adcrp_top adcrp_top_monitor #(.DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH)) adcrp_top_monitor_i (
  .i_sys_clk, .i_resetn, .i_analog_code, .i_converter_select_address_bit,
  .i_io_space_strobe_n, .o_bus_data, .o_bus_data_oe, .o_drv_oe_n, .o_conv_data,
  .o_sample_valid, .o_overrun);

/* File: tb/adcrp_reader.sv */
// Purpose: processor side reader model
// Assumes: one read access per go pulse
// Notes:   strobe may be withheld to make a refused access
`timescale 1ns/10ps
module adcrp_reader #(
  parameter int HOLD = 6
) (
  input  wire logic i_sys_clk,
  input  wire logic i_go,
  input  wire logic i_stb_en,
  output logic      o_sel,
  output logic      o_stb_n
);
  // no interrupt source in this model, so the capture loop is never broken
  int cnt = 0;
  initial
  begin
    o_sel = 1'b0;
    o_stb_n = 1'b1;
  end
  // address and strobe move together and stand for the whole access
  always @(posedge i_sys_clk)
  begin
    cnt <= cnt + 1;
    if (i_go)
    begin
      o_sel <= 1'b1;
      o_stb_n <= !i_stb_en;
      cnt <= 0;
    end
    else if (cnt == HOLD)
    begin
      o_sel <= 1'b0;
      o_stb_n <= 1'b1;
    end
  end
endmodule

/* File: tb/testbench.sv */
// Purpose: self checking bench for the converter read port
// Assumes: 20 MHz clock, reader model on the processor side
// Notes:   codes are held long enough for the pipeline to settle
`timescale 1ns/10ps
module testbench;
  logic i_sys_clk = 1'b0, i_resetn = 1'b0, go = 1'b0, stb_en = 1'b1, sel, stb_n;
  logic oe, oe_n, vld, ovr, oe_q = 1'b0;
  logic [31:0] rs = 32'h0000b6d8;
  adcrp_pkg::adcrp_byte_t code = 8'h00, bus, conv, expq[$];
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial forever #25 i_sys_clk = ~i_sys_clk;
  adcrp_top adcrp_top_i (.i_sys_clk, .i_resetn, .i_analog_code(code),
    .i_converter_select_address_bit(sel), .i_io_space_strobe_n(stb_n), .o_bus_data(bus),
    .o_bus_data_oe(oe), .o_drv_oe_n(oe_n), .o_conv_data(conv), .o_sample_valid(vld),
    .o_overrun(ovr));
  adcrp_reader adcrp_reader_i (.i_sys_clk, .i_go(go), .i_stb_en(stb_en), .o_sel(sel),
    .o_stb_n(stb_n));
  // watcher: each start of a driven read takes the oldest note
  always @(posedge i_sys_clk)
  begin
    oe_q <= oe;
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    if (oe === 1'b1 && oe_q === 1'b0)
    begin
      samples_checked++;
      if (expq.size() == 0 || bus !== expq[0])
      begin
        n_mismatch++;
        $display("[FAIL] %0t read data", $time);
      end
      if (expq.size() > 0)
        void'(expq.pop_front());
    end
  end
  // stimulus: new code, settle, then one or two reads; both reads for code 3 lack strobe
  initial
  begin
    repeat (10) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    // capture constants fixed up front: fourteen samples, one converter address
    for (int i = 0; i < 14; i++)
    begin
      rs = xs(rs);
      code <= rs[7:0];
      repeat (10) @(posedge i_sys_clk);
      samples_checked++;
      if (conv !== rs[7:0])
      begin
        n_mismatch++;
        $display("[FAIL] %0t newest result", $time);
      end
      repeat (i % 2 + 1)
      begin
        if (i != 3)
          expq.push_back(rs[7:0]);
        stb_en <= (i != 3);
        go <= 1'b1;
        @(posedge i_sys_clk);
        go <= 1'b0;
        repeat (14) @(posedge i_sys_clk);
      end
    end
    i_resetn <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    samples_checked++;
    if (expq.size() != 0 || oe !== 1'b0 || oe_n !== 1'b1)
    begin
      n_mismatch++;
      $display("[FAIL] %0t end state", $time);
    end
    tally_and_finish();
  end
endmodule
